/* File: sync_serial_defines.vh */
// register indices, bit positions, modes and counts of the sync serial port
`ifndef SYNC_SERIAL_DEFINES_VH
`define SYNC_SERIAL_DEFINES_VH

// ---------------------------------------------------------------
// register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define IDX_INTERRUPT_CONTROL 8'h0B
`define IDX_PERIPHERAL_IRQ_FLAGS 8'h0C
`define IDX_BUS_EVENT_FLAGS 8'h0D
`define IDX_SHIFT_BUFFER 8'h13
`define IDX_SYNC_PORT_CONTROL 8'h14
`define IDX_PORT_A_DIRECTION 8'h85
`define IDX_PORT_C_DIRECTION 8'h87
`define IDX_PERIPHERAL_IRQ_ENABLES 8'h8C
`define IDX_SECOND_PORT_CONTROL 8'h91
`define IDX_RATE_RELOAD_VALUE 8'h93
`define IDX_SYNC_PORT_STATUS 8'h94

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define CTL_WRITE_COLLISION_FLAG 7
`define CTL_OVF 6
`define CTL_EN 5
`define CTL_CKP 4
`define STA_SMP 7
`define STA_CKE 6
`define STA_START 3
`define STA_BF 0
`define PIR_SPIF 3
`define BEF_BCOL 3
`define DIRC_SDO 5
`define DIRC_SCK 3
`define DIRA_SS 5
`define CTL2_SEN 0

// ---------------------------------------------------------------
// mode codes
// ---------------------------------------------------------------
`define MODE_M_DIV4 4'h0
`define MODE_M_DIV16 4'h1
`define MODE_M_DIV64 4'h2
`define MODE_M_TMR 4'h3
`define MODE_S_SS 4'h4
`define MODE_S_NOSS 4'h5
`define MODE_I2C_M 4'h8

// ---------------------------------------------------------------
// reset values and counts
// ---------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_DIR 8'hFF
`define HALF_DIV4 6'h02
`define HALF_DIV16 6'h08
`define HALF_DIV64 6'h20
`define SPI_LAST_EDGE 5'h10

`endif

/* File: sync_serial_port.v */
// sync serial port: spi engine, i2c start sequencer and ahb-lite registers
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ns
`include "sync_serial_defines.vh"

module sync_serial_port
(
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output wire [31:0] hrdata,
	input wire tmr2_tick,
	input wire sck_in,
	output wire sck_out,
	output wire sck_oe,
	input wire sdi,
	output wire sdo,
	output wire sdo_oe,
	input wire ss_n,
	input wire sda_in,
	output wire sda_out,
	output wire sda_oe,
	input wire scl_in,
	output wire scl_out,
	output wire scl_oe
);

// ---------------------------------------------------------------
// states and helpers
// ---------------------------------------------------------------
localparam I_IDLE = 2'b00;
localparam I_CHECK = 2'b01;
localparam I_RISE = 2'b10;
localparam I_HOLD = 2'b11;

function [5:0] half_of;
	input [1:0] m;
	begin
		case (m)
		2'b00: half_of = `HALF_DIV4;
		2'b01: half_of = `HALF_DIV16;
		default: half_of = `HALF_DIV64;
		endcase
	end
endfunction

// ---------------------------------------------------------------
// registers
// ---------------------------------------------------------------
reg [7:0] interrupt_control_ff;
reg [7:0] pir_ff;
reg [7:0] pie_ff;
reg [7:0] bef_ff;
reg [7:0] ctl_ff;
reg [7:0] ctl2_ff;
reg [7:0] reload_ff;
reg [7:0] dira_ff;
reg [7:0] dirc_ff;
reg smp_ff;
reg cke_ff;
reg bf_ff;
reg start_ff;
reg [7:0] buf_ff;
reg wr_pend_ff;
reg [7:0] wr_idx_ff;
reg [31:0] hrdata_ff;
reg [7:0] rd_val;
reg [7:0] tx_ff;
reg [7:0] rx_ff;
reg busy_ff;
reg tog_ff;
reg [4:0] edge_ff;
reg [5:0] div_ff;
reg [2:0] capn_ff;
reg sck_prev_ff;
reg [1:0] ist_ff;
reg [1:0] nxt_ist;
reg [6:0] brg_ff;
reg [6:0] nxt_brg;
reg sda_low_ff;
reg nxt_sda_low;
reg sen_clr;
reg bcol_set;
reg start_set;

// ---------------------------------------------------------------
// bus decode
// ---------------------------------------------------------------
wire acc = hsel && htrans[1] && hready;
wire a_ok = haddr[31:10] == 22'h000000;
wire [7:0] a_idx = haddr[9:2];
wire rd_acc = acc && !hwrite && a_ok;
wire [7:0] wd = hwdata[7:0];
wire we = wr_pend_ff;
wire wr_ctl = we && wr_idx_ff == `IDX_SYNC_PORT_CONTROL;
wire wr_ctl2 = we && wr_idx_ff == `IDX_SECOND_PORT_CONTROL;
wire wr_sta = we && wr_idx_ff == `IDX_SYNC_PORT_STATUS;
wire wr_buf = we && wr_idx_ff == `IDX_SHIFT_BUFFER;
wire wr_pir = we && wr_idx_ff == `IDX_PERIPHERAL_IRQ_FLAGS;
wire wr_bef = we && wr_idx_ff == `IDX_BUS_EVENT_FLAGS;
wire rd_buf = rd_acc && a_idx == `IDX_SHIFT_BUFFER;

assign hreadyout = 1'b1;
assign hresp = 1'b0;
assign hrdata = hrdata_ff;

// ---------------------------------------------------------------
// mode decode and pin ownership
// ---------------------------------------------------------------
wire en = ctl_ff[`CTL_EN];
wire clock_idle_polarity = ctl_ff[`CTL_CKP];
wire [3:0] mode = ctl_ff[3:0];
wire spi_m = en && mode <= `MODE_M_TMR;
wire spi_s = en && (mode == `MODE_S_SS || mode == `MODE_S_NOSS);
wire spi_on = spi_m || spi_s;
wire i2c_m = en && mode == `MODE_I2C_M;
wire start_enable_bit = ctl2_ff[`CTL2_SEN];
wire ss_used = mode == `MODE_S_SS && dira_ff[`DIRA_SS];
wire ss_off = spi_s && ss_used && ss_n;
wire sck_ok = dirc_ff[`DIRC_SCK];

assign sck_out = clock_idle_polarity ^ tog_ff;
assign sck_oe = spi_m && !dirc_ff[`DIRC_SCK];
assign sdo = tx_ff[7];
assign sdo_oe = spi_on && !dirc_ff[`DIRC_SDO] && !ss_off;
assign sda_out = 1'b0;
assign sda_oe = sda_low_ff;
assign scl_out = 1'b0;
assign scl_oe = 1'b0;

// ---------------------------------------------------------------
// spi event decode
// ---------------------------------------------------------------
wire [5:0] half = half_of(mode[1:0]);
wire tick = (mode == `MODE_M_TMR) ? tmr2_tick : (div_ff == half - 6'h01);
wire m_ev = spi_m && busy_ff && tick;
wire e_odd = edge_ff[0];
wire e_last = edge_ff == `SPI_LAST_EDGE;
wire e_zero = edge_ff == 5'h00;
wire m_cap_mid = !e_last && (cke_ff ? !e_odd : e_odd);
wire m_cap_end = cke_ff ? e_odd : (!e_odd && !e_zero);
wire m_cap = smp_ff ? m_cap_end : m_cap_mid;
wire m_shf = !e_last && (cke_ff ? e_odd : (!e_odd && !e_zero));
wire sl_ev = spi_s && sck_ok && !ss_off && (sck_in != sck_prev_ff);
wire lead = sck_in != clock_idle_polarity;
wire s_cap = sl_ev && (cke_ff ? lead : !lead);
wire s_shf = sl_ev && (cke_ff ? !lead : (lead && capn_ff != 3'h0));
wire ev_cap = (m_ev && m_cap) || s_cap;
wire ev_shf = (m_ev && m_shf) || s_shf;
wire ev_done = (m_ev && e_last) || (s_cap && capn_ff == 3'h7);
wire [7:0] rx_nxt = ev_cap ? {rx_ff[6:0], sdi} : rx_ff;
wire spi_busy = (spi_m && busy_ff) || (spi_s && capn_ff != 3'h0);
wire buf_block = spi_busy || start_enable_bit;
wire buf_ok = wr_buf && !buf_block;
wire ovf_set = ev_done && spi_s && bf_ff;
wire fill = ev_done && !ovf_set;

// ---------------------------------------------------------------
// ahb-lite slave
// ---------------------------------------------------------------
always @*
begin
	case (a_idx)
	`IDX_INTERRUPT_CONTROL: rd_val = interrupt_control_ff;
	`IDX_PERIPHERAL_IRQ_FLAGS: rd_val = pir_ff;
	`IDX_BUS_EVENT_FLAGS: rd_val = bef_ff;
	`IDX_SHIFT_BUFFER: rd_val = buf_ff;
	`IDX_SYNC_PORT_CONTROL: rd_val = ctl_ff;
	`IDX_PORT_A_DIRECTION: rd_val = dira_ff;
	`IDX_PORT_C_DIRECTION: rd_val = dirc_ff;
	`IDX_PERIPHERAL_IRQ_ENABLES: rd_val = pie_ff;
	`IDX_SECOND_PORT_CONTROL: rd_val = ctl2_ff;
	`IDX_RATE_RELOAD_VALUE: rd_val = reload_ff;
	`IDX_SYNC_PORT_STATUS: rd_val = {smp_ff, cke_ff, 2'b00, start_ff, 2'b00, bf_ff};
	default: rd_val = 8'h00;
	endcase
end

always @(posedge hclk or negedge hresetn)
begin
	if (!hresetn)
	begin
		wr_pend_ff <= 1'b0;
		wr_idx_ff <= 8'h00;
		hrdata_ff <= 32'h00000000;
	end
	else
	begin
		wr_pend_ff <= acc && hwrite && a_ok;
		wr_idx_ff <= a_idx;
		if (rd_acc)
			hrdata_ff <= {24'h000000, rd_val};
	end
end

// ---------------------------------------------------------------
// software registers and hardware flags
// ---------------------------------------------------------------
always @(posedge hclk or negedge hresetn)
begin
	if (!hresetn)
	begin
		interrupt_control_ff <= `RST_BYTE;
		pir_ff <= `RST_BYTE;
		pie_ff <= `RST_BYTE;
		bef_ff <= `RST_BYTE;
		ctl_ff <= `RST_BYTE;
		ctl2_ff <= `RST_BYTE;
		reload_ff <= `RST_BYTE;
		dira_ff <= `RST_DIR;
		dirc_ff <= `RST_DIR;
		smp_ff <= 1'b0;
		cke_ff <= 1'b0;
		bf_ff <= 1'b0;
		start_ff <= 1'b0;
		buf_ff <= `RST_BYTE;
	end
	else
	begin
		if (we && wr_idx_ff == `IDX_INTERRUPT_CONTROL)
			interrupt_control_ff <= wd;
		if (we && wr_idx_ff == `IDX_PERIPHERAL_IRQ_ENABLES)
			pie_ff <= wd;
		if (we && wr_idx_ff == `IDX_RATE_RELOAD_VALUE)
			reload_ff <= wd;
		if (we && wr_idx_ff == `IDX_PORT_A_DIRECTION)
			dira_ff <= wd;
		if (we && wr_idx_ff == `IDX_PORT_C_DIRECTION)
			dirc_ff <= wd;
		if (wr_sta)
		begin
			smp_ff <= wd[`STA_SMP];
			cke_ff <= wd[`STA_CKE];
		end
		if (wr_ctl)
			ctl_ff[5:0] <= wd[5:0];
		if (wr_buf && buf_block)
			ctl_ff[`CTL_WRITE_COLLISION_FLAG] <= 1'b1;
		else if (wr_ctl)
			ctl_ff[`CTL_WRITE_COLLISION_FLAG] <= wd[`CTL_WRITE_COLLISION_FLAG];
		if (ovf_set)
			ctl_ff[`CTL_OVF] <= 1'b1;
		else if (wr_ctl)
			ctl_ff[`CTL_OVF] <= wd[`CTL_OVF];
		if (wr_pir)
			pir_ff <= wd;
		if (ev_done)
			pir_ff[`PIR_SPIF] <= 1'b1;
		if (wr_bef)
			bef_ff <= wd;
		if (bcol_set)
			bef_ff[`BEF_BCOL] <= 1'b1;
		if (fill)
		begin
			buf_ff <= rx_nxt;
			bf_ff <= 1'b1;
		end
		else if (rd_buf)
			bf_ff <= 1'b0;
		if (!i2c_m)
			start_ff <= 1'b0;
		else if (start_set)
			start_ff <= 1'b1;
		if (wr_ctl2 && start_enable_bit)
			ctl2_ff <= {wd[7:5], ctl2_ff[4:1], 1'b0 | !sen_clr};
		else if (wr_ctl2)
			ctl2_ff <= wd;
		else if (sen_clr)
			ctl2_ff[`CTL2_SEN] <= 1'b0;
	end
end

// ---------------------------------------------------------------
// spi engine
// ---------------------------------------------------------------
always @(posedge hclk or negedge hresetn)
begin
	if (!hresetn)
	begin
		tx_ff <= `RST_BYTE;
		rx_ff <= `RST_BYTE;
		busy_ff <= 1'b0;
		tog_ff <= 1'b0;
		edge_ff <= 5'h00;
		div_ff <= 6'h00;
		capn_ff <= 3'h0;
		sck_prev_ff <= 1'b0;
	end
	else
	begin
		sck_prev_ff <= sck_in;
		if (!spi_on)
		begin
			busy_ff <= 1'b0;
			tog_ff <= 1'b0;
			edge_ff <= 5'h00;
			div_ff <= 6'h00;
			capn_ff <= 3'h0;
		end
		else
		begin
			if (buf_ok)
				tx_ff <= wd;
			else if (ev_shf)
				tx_ff <= {tx_ff[6:0], 1'b0};
			if (ev_cap)
				rx_ff <= rx_nxt;
			if (buf_ok && spi_m)
			begin
				busy_ff <= 1'b1;
				tog_ff <= 1'b0;
				edge_ff <= 5'h00;
				div_ff <= 6'h00;
			end
			else if (m_ev)
			begin
				div_ff <= 6'h00;
				if (!e_last)
					tog_ff <= ~tog_ff;
				if (e_last)
					busy_ff <= 1'b0;
				else
					edge_ff <= edge_ff + 5'h01;
			end
			else if (spi_m && busy_ff)
				div_ff <= div_ff + 6'h01;
			if (ss_off)
				capn_ff <= 3'h0;
			else if (s_cap)
				capn_ff <= capn_ff + 3'h1;
		end
	end
end

// ---------------------------------------------------------------
// i2c start sequencer
// ---------------------------------------------------------------
always @*
begin
	nxt_ist = ist_ff;
	nxt_brg = brg_ff;
	nxt_sda_low = sda_low_ff;
	sen_clr = 1'b0;
	bcol_set = 1'b0;
	start_set = 1'b0;
	case (ist_ff)
	I_IDLE:
	begin
		if (i2c_m && start_enable_bit)
			nxt_ist = I_CHECK;
	end
	I_CHECK:
	begin
		if (sda_in && scl_in)
		begin
			nxt_brg = reload_ff[6:0];
			nxt_ist = I_RISE;
		end
		else if (!sda_in && !scl_in)
		begin
			bcol_set = 1'b1;
			sen_clr = 1'b1;
			nxt_sda_low = 1'b0;
			nxt_ist = I_IDLE;
		end
	end
	I_RISE:
	begin
		if (!scl_in || (brg_ff == 7'h00 && !sda_in))
		begin
			bcol_set = 1'b1;
			sen_clr = 1'b1;
			nxt_sda_low = 1'b0;
			nxt_ist = I_IDLE;
		end
		else if (brg_ff == 7'h00)
		begin
			nxt_sda_low = 1'b1;
			start_set = 1'b1;
			nxt_brg = reload_ff[6:0];
			nxt_ist = I_HOLD;
		end
		else
			nxt_brg = brg_ff - 7'h01;
	end
	default:
	begin
		if (brg_ff == 7'h00)
		begin
			sen_clr = 1'b1;
			nxt_ist = I_IDLE;
		end
		else
			nxt_brg = brg_ff - 7'h01;
	end
	endcase
	if (!i2c_m)
	begin
		nxt_ist = I_IDLE;
		nxt_sda_low = 1'b0;
		sen_clr = 1'b0;
		bcol_set = 1'b0;
		start_set = 1'b0;
	end
end

always @(posedge hclk or negedge hresetn)
begin
	if (!hresetn)
	begin
		ist_ff <= I_IDLE;
		brg_ff <= 7'h00;
		sda_low_ff <= 1'b0;
	end
	else
	begin
		ist_ff <= nxt_ist;
		brg_ff <= nxt_brg;
		sda_low_ff <= nxt_sda_low;
	end
end

endmodule

/* File: sync_serial_sva.sv */
// port checker of the sync serial port
`timescale 1ns/1ns
module sync_serial_sva
(
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire hready,
	input wire hreadyout,
	input wire hresp,
	input wire [31:0] hrdata,
	input wire tmr2_tick,
	input wire sck_out,
	input wire sck_oe,
	input wire scl_in,
	input wire sda_out,
	input wire sda_oe,
	input wire scl_oe
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	sequence s_read_taken;
		hsel && htrans[1] && hready && !hwrite;
	endsequence
	sequence s_drop;
		$rose(sda_oe);
	endsequence
	chk_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus answer not okay");
	chk_rdata_upper: assert property (hrdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	chk_rdata_hold: assert property (!(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
		else $error("read data moved without read");
	chk_sck_half: assert property (sck_oe && $changed(sck_out) |=> $stable(sck_out) || $past(tmr2_tick))
		else $error("serial clock half period short");
	chk_modes_apart: assert property (!(sck_oe && sda_oe))
		else $error("spi and i2c drive together");
	chk_no_scl: assert property (!scl_oe && !sda_out)
		else $error("clock line driven");
	chk_start_scl: assert property (s_drop |-> scl_in)
		else $error("data pulled low while clock low");
	chk_start_hold: assert property (s_drop |=> sda_oe [*6])
		else $error("data line not held low");
	cover property (s_read_taken);
endmodule

/* File: spi_peer_model.sv */
// spi slave peer on the far side of the serial link
`timescale 1ns/1ns
module spi_peer_model
(
	input wire sck,
	input wire sdo,
	input wire cpol,
	input wire cke,
	input wire load,
	input wire [7:0] tx,
	output reg sdi,
	output reg [7:0] rx
);
	integer n;
	initial
	begin
		sdi = 1'h0;
		rx = 8'h00;
		n = 0;
	end
	always @(posedge load)
	begin
		n = cke ? 1 : 0;
		sdi = cke ? tx[7] : ~tx[7];
	end
	always @(sck)
	begin
		if ((sck !== cpol) == cke)
			rx <= {rx[6:0], sdo};
		else
		begin
			sdi <= (n < 8) ? tx[7 - n] : ~sdi;
			n = n + 1;
		end
	end
endmodule

/* File: sync_serial_spi_i2c_start_bench.sv */
// self-checking bench of the sync serial port
`timescale 1ns/1ns
`include "sync_serial_defines.vh"
module sync_serial_spi_i2c_start_bench;
	localparam [7:0] ctl_i = `IDX_SYNC_PORT_CONTROL;
	localparam [7:0] sta_i = `IDX_SYNC_PORT_STATUS;
	localparam [7:0] buf_i = `IDX_SHIFT_BUFFER;
	localparam [7:0] pir_i = `IDX_PERIPHERAL_IRQ_FLAGS;
	localparam [7:0] ct2_i = `IDX_SECOND_PORT_CONTROL;
	reg hclk = 1'h0;
	reg hresetn = 1'h0;
	reg hsel = 1'h0;
	reg [31:0] haddr = 32'h0;
	reg [1:0] htrans = 2'h0;
	reg hwrite = 1'h0;
	reg [31:0] hwdata = 32'h0;
	reg tmr2_tick = 1'h0;
	reg [1:0] tc = 2'h0;
	reg sda_low = 1'h0;
	reg scl_low = 1'h0;
	reg pol = 1'h0;
	reg cke = 1'h0;
	reg load = 1'h0;
	reg [7:0] ptx = 8'h0;
	reg [7:0] rd = 8'h0;
	reg [24:0] rows [0:8];
	integer num_errors = 0;
	integer n_compared = 0;
	integer i;
	integer j;
	wire hreadyout, hresp, sck_out, sck_oe, sdo, sdo_oe, sda_oe, scl_oe, sdi;
	wire [31:0] hrdata;
	wire [7:0] prx;
	wire sck = sck_oe ? sck_out : pol;
	wire sda = !(sda_oe || sda_low);
	wire scl = !(scl_oe || scl_low);
	sync_serial_port i_sync_serial_port
	(
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(3'h2),
		.hwdata(hwdata),
		.hready(hreadyout),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.hrdata(hrdata),
		.tmr2_tick(tmr2_tick),
		.sck_in(sck),
		.sck_out(sck_out),
		.sck_oe(sck_oe),
		.sdi(sdi),
		.sdo(sdo),
		.sdo_oe(sdo_oe),
		.ss_n(1'h1),
		.sda_in(sda),
		.sda_out(),
		.sda_oe(sda_oe),
		.scl_in(scl),
		.scl_out(),
		.scl_oe(scl_oe)
	);
	spi_peer_model i_spi_peer_model
	(
		.sck(sck), .sdo(sdo), .cpol(pol), .cke(cke),
		.load(load), .tx(ptx), .sdi(sdi), .rx(prx)
	);
	initial
	begin
		forever #25 hclk = ~hclk;
	end
	always @(posedge hclk)
	begin
		tc <= tc + 2'h1;
		tmr2_tick <= (tc == 2'h3);
	end
	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task final_report;
	begin
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	end
	endtask
	task chk(input [7:0] got, input [7:0] exp);
	begin
		n_compared = n_compared + 1;
		if (got !== exp)
		begin
			num_errors = num_errors + 1;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	end
	endtask
	task wait_rdy;
	begin
		j = 0;
		@(posedge hclk);
		while (hreadyout !== 1'h1)
		begin
			j = j + 1;
			if (j > 50)
			begin
				num_errors = num_errors + 1;
				final_report;
			end
			@(posedge hclk);
		end
	end
	endtask
	task bus(input w, input [7:0] idx, input [7:0] d);
	begin
		hsel <= 1'h1;
		haddr <= {22'h0, idx, 2'h0};
		hwrite <= w;
		htrans <= 2'h2;
		wait_rdy;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		wait_rdy;
		rd = hrdata[7:0];
		@(posedge hclk);
	end
	endtask
	task poll(input [7:0] idx, input [7:0] m, input [7:0] v);
	integer t;
	begin
		t = 0;
		bus(1'h0, idx, 8'h00);
		while ((rd & m) !== v)
		begin
			t = t + 1;
			if (t > 400)
			begin
				num_errors = num_errors + 1;
				final_report;
			end
			bus(1'h0, idx, 8'h00);
		end
	end
	endtask
	// ---------------------------------------------------------------
	// sequence
	// ---------------------------------------------------------------
	initial
	begin
		rows[0] = {1'h0, ctl_i, 8'h00, 8'h00};
		rows[1] = {1'h0, sta_i, 8'h00, 8'h00};
		rows[2] = {1'h0, `IDX_PORT_C_DIRECTION, 8'h00, 8'hFF};
		rows[3] = {1'h1, 8'h20, 8'h5A, 8'h00};
		rows[4] = {1'h0, 8'h20, 8'h00, 8'h00};
		rows[5] = {1'h1, sta_i, 8'hFF, 8'h00};
		rows[6] = {1'h0, sta_i, 8'h00, 8'hC0};
		rows[7] = {1'h1, ctl_i, 8'h1F, 8'h00};
		rows[8] = {1'h0, ctl_i, 8'h00, 8'h1F};
		repeat (12) @(posedge hclk);
		chk({6'h0, sck_oe, sda_oe}, 8'h00);
		hresetn <= 1'h1;
		@(posedge hclk);
		for (i = 0; i < 9; i = i + 1)
		begin
			bus(rows[i][24], rows[i][23:16], rows[i][15:8]);
			if (!rows[i][24])
				chk(rd, rows[i][7:0]);
		end
		bus(1'h1, `IDX_PORT_C_DIRECTION, 8'h00);
		for (i = 0; i < 4; i = i + 1)
		begin
			bus(1'h1, ctl_i, 8'h00);
			chk({6'h0, sck_oe, sdo_oe}, 8'h00);
			pol = i[0];
			cke = i[1];
			bus(1'h1, sta_i, {i[0] ^ i[1], cke, 6'h0});
			bus(1'h1, ctl_i, {3'h1, pol, 2'h0, i[1:0]});
			chk({6'h0, sck_oe, sdo_oe}, 8'h03);
			ptx = 8'h3C + i[7:0];
			load = 1'h1;
			bus(1'h1, buf_i, 8'hA5 ^ i[7:0]);
			bus(1'h1, buf_i, 8'h00);
			load = 1'h0;
			poll(pir_i, 8'h08, 8'h08);
			bus(1'h0, sta_i, 8'h00);
			chk(rd, {i[0] ^ i[1], cke, 5'h0, 1'h1});
			bus(1'h0, ctl_i, 8'h00);
			chk(rd, {3'h5, pol, 2'h0, i[1:0]});
			bus(1'h0, buf_i, 8'h00);
			chk(rd, ptx);
			chk(prx, 8'hA5 ^ i[7:0]);
			bus(1'h1, pir_i, 8'h00);
		end
		bus(1'h1, `IDX_PORT_C_DIRECTION, 8'h28);
		chk({6'h0, sck_oe, sdo_oe}, 8'h00);
		bus(1'h1, ctl_i, 8'h00);
		bus(1'h1, ctl_i, 8'h28);
		sda_low <= 1'h1;
		scl_low <= 1'h1;
		bus(1'h1, ct2_i, 8'h01);
		repeat (2) @(posedge hclk);
		bus(1'h0, `IDX_BUS_EVENT_FLAGS, 8'h00);
		chk(rd, 8'h08);
		bus(1'h0, ct2_i, 8'h00);
		chk(rd, 8'h00);
		sda_low <= 1'h0;
		scl_low <= 1'h0;
		bus(1'h1, `IDX_RATE_RELOAD_VALUE, 8'h7F);
		bus(1'h1, ct2_i, 8'h01);
		bus(1'h1, ct2_i, 8'h1E);
		bus(1'h1, buf_i, 8'h99);
		poll(sta_i, 8'h08, 8'h08);
		chk({7'h0, sda_oe}, 8'h01);
		poll(ct2_i, 8'h01, 8'h00);
		chk(rd, 8'h00);
		bus(1'h0, ctl_i, 8'h00);
		chk(rd, 8'hA8);
		bus(1'h0, buf_i, 8'h00);
		chk(rd, 8'h3F);
		chk({7'h0, sda_oe}, 8'h01);
		final_report;
	end
endmodule
bind sync_serial_port sync_serial_sva i_sync_serial_sva
(
	.hclk(hclk),
	.hresetn(hresetn),
	.hsel(hsel),
	.htrans(htrans),
	.hwrite(hwrite),
	.hready(hready),
	.hreadyout(hreadyout),
	.hresp(hresp),
	.hrdata(hrdata),
	.tmr2_tick(tmr2_tick),
	.sck_out(sck_out),
	.sck_oe(sck_oe),
	.scl_in(scl_in),
	.sda_out(sda_out),
	.sda_oe(sda_oe),
	.scl_oe(scl_oe)
);
